// ---- hdl/bdc_pkg.sv ----
// Operation
// - debug access holds internal buses; multi-cycle access freezes processor clocks
// - lockout forbids active debug mode and removes debug rom from the map
// - lockout bit reloads from shadow byte at every reset; zero means locked
// - lockout bit changes only in special modes, mode pin low
// - erasing the shadow byte sets the lockout bit at next reset
// - under lockout, reset-vector code cannot run in special single-chip mode
// - seven debug register bytes sit at FF00 to FF06 while active
// - status bits 3-5,7 always writable; 6 only firmware, 2 only hardware
// - status resets to zero; active flag resets to one in special modes; code does so only in special single-chip and peripheral modes
// - enable flag zero refuses active mode and firmware commands, not hardware ones
// - active flag sets on entry, maps rom; writes take effect after 4 cycles
// - tagging set by tag-and-go, cleared on entry; serial off 16 cycles after write; code disables serial from the write on and enables tagging 16 cycles later
// - shifter-valid reads one after a completed shift, zero while shifting
// - trace flag set when single-step command issues
// - clock select: zero bus clock, one system clock; host retimes after 150 cycles
// - slow system clock overrides clock select and drives debug logic
// - 512 debug clocks between host falling edges clears instruction register
// - hardware instruction layout: hw, data, read, background, word, map, zeros
// - word/byte flag one means word transfer, zero byte transfer
// - map flag one places debug resources at FF00-FFFF for hardware accesses
package bdc_pkg;
  localparam int          ADDR_W         = 16;
  // register byte addresses in the processor map
  localparam logic [15:0] OFS_INSTR      = 16'hFF00;
  localparam logic [15:0] OFS_STATUS     = 16'hFF01;
  localparam logic [15:0] OFS_SHIFT_HI   = 16'hFF02;
  localparam logic [15:0] OFS_SHIFT_LO   = 16'hFF03;
  localparam logic [15:0] OFS_ADDR_HI    = 16'hFF04;
  localparam logic [15:0] OFS_ADDR_LO    = 16'hFF05;
  localparam logic [15:0] OFS_CCR        = 16'hFF06;
  localparam logic [15:0] MAP_BASE       = 16'hFF00;
  // status field positions
  localparam int          ST_ENABLE      = 7;
  localparam int          ST_ACTIVE      = 6;
  localparam int          ST_TAG         = 5;
  localparam int          ST_SDV         = 4;
  localparam int          ST_TRACE       = 3;
  localparam int          ST_CLKSEL      = 2;
  // instruction field positions
  localparam int          IN_HW          = 7;
  localparam int          IN_WORD        = 3;
  localparam int          IN_MAP         = 2;
  localparam logic [7:0]  INSTR_RST      = 8'h00;
  localparam logic [7:0]  OPC_BACKGROUND = 8'h90;
  localparam logic [7:0]  HW_LOW_MASK    = 8'hFC;
  // cycle counts
  localparam int          ACT_DLY_CYC    = 4;
  localparam int          TAG_DLY_CYC    = 16;
  localparam int          TMO_CYC        = 512;
  localparam int          HOST_FWWR_CYC  = 32;
  localparam int          HOST_EXIT_CYC  = 64;
  localparam int          HOST_CLOCK_SELECT_BIT_CYC = 150;
endpackage : bdc_pkg

// ---- hdl/bdc_sync.sv ----
`timescale 1ns/10ps
module bdc_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // async level in, synchronised level out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule : bdc_sync

// ---- hdl/bdc_delay.sv ----
`timescale 1ns/10ps
module bdc_delay #(
  parameter int COUNT = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // start restarts the count; done is taken at the COUNT-th edge after start
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt_ff;
  logic          busy_ff;
  logic [CW-1:0] nxt_cnt;
  logic          nxt_busy;

  // a restart swallows the pending expiry, so overlapping writes extend the wait
  assign done     = busy_ff && (cnt_ff == CW'(1)) && !start;
  assign nxt_cnt  = start ? CW'(COUNT) : (busy_ff ? cnt_ff - CW'(1) : cnt_ff);
  assign nxt_busy = start || (busy_ff && !done);
  assign busy     = busy_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end
endmodule : bdc_delay

// ---- hdl/bdc_ctrl.sv ----
`timescale 1ns/10ps
module bdc_ctrl
  import bdc_pkg::*;
(
  // clock and reset; CLK_SYS is the selected debug clock
  input  wire logic                    CLK_SYS,
  input  wire logic                    RESET,
  // pins and straps
  input  wire logic                    BACKGROUND_PIN_IN,
  input  wire logic                    SPECIAL_MODE_N,
  input  wire logic                    MODE_SPECIAL_SC,
  input  wire logic                    MODE_PERIPH,
  input  wire logic                    SYS_CLK_SLOW,
  // nonvolatile lockout bit and its config write
  input  wire logic                    SHADOW_LOCKOUT_OFF,
  input  wire logic                    LOCK_WR,
  input  wire logic                    LOCK_WDATA,
  // processor-side register access
  input  wire logic [bdc_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  input  wire logic [7:0]              REG_WDATA,
  output logic                         REG_HIT,
  output logic      [7:0]              REG_RDATA,
  // serial engine events
  input  wire logic                    CMD_STROBE,
  input  wire logic [7:0]              CMD_BYTE,
  input  wire logic                    SHIFT_START,
  input  wire logic                    SHIFT_DONE,
  input  wire logic [15:0]             SHIFT_DATA_IN,
  input  wire logic                    ADDR_LOAD,
  input  wire logic [15:0]             ADDR_IN,
  input  wire logic                    ENTER_REQ,
  input  wire logic                    SINGLE_STEP_CMD,
  input  wire logic                    TAG_GO_CMD,
  input  wire logic                    CCR_LOAD,
  input  wire logic [7:0]              CCR_IN,
  // memory access stealing
  input  wire logic                    MEM_REQ,
  input  wire logic                    MEM_MULTI,
  input  wire logic                    MEM_DONE,
  output logic                         BUS_HOLD,
  output logic                         CPU_FREEZE,
  // control outputs
  output logic                         DEBUG_ACTIVE,
  output logic                         DEBUG_MAP_EN,
  output logic                         FW_CMD_ALLOWED,
  output logic                         LOCKOUT_OFF,
  output logic                         RESET_VEC_RUN_EN,
  output logic                         TAG_ENABLE,
  output logic                         SERIAL_DISABLE,
  output logic                         DEBUG_CLK_SEL,
  output logic                         XFER_WORD,
  output logic      [15:0]             SHIFT_DATA,
  output logic      [15:0]             ADDR_HOLD
);
  import bdc_pkg::*;

  logic [7:0]  instr_ff;
  logic        enable_ff, active_ff, tag_ff, tag_live_ff, sdv_ff, trace_ff, clksel_ff;
  logic        act_wval_ff, lockout_off_ff, mem_pend_ff, mem_multi_ff, background_pin_d_ff;
  logic [15:0] shift_ff, addr_ff;
  logic [7:0]  ccr_ff, rdata_ff;
  logic        background_pin_s, special_n_s, special_sc_s, periph_s, sys_slow_s;
  logic        act_done, tag_busy, tag_done, tmo_done;

  // pin levels cross into the debug clock; background pin idles high
  bdc_sync #(.W(1), .INIT(1'b1)) u_sync_background_pin (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .din  (BACKGROUND_PIN_IN),
    .dout (background_pin_s)
  );
  bdc_sync #(.W(4), .INIT(4'h8)) u_sync_mode (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .din  ({SPECIAL_MODE_N, MODE_SPECIAL_SC, MODE_PERIPH, SYS_CLK_SLOW}),
    .dout ({special_n_s, special_sc_s, periph_s, sys_slow_s})
  );

  // address decode; debug space only answers while mapped
  wire logic        map_en    = lockout_off_ff && (active_ff || (instr_ff[IN_HW] && instr_ff[IN_MAP]));
  wire logic        in_space  = (REG_ADDR >= OFS_INSTR) && (REG_ADDR <= OFS_CCR);
  wire logic        reg_sel   = map_en && in_space;
  wire logic        wr_instr  = reg_sel && REG_WR && (REG_ADDR == OFS_INSTR);
  wire logic        st_wr     = reg_sel && REG_WR && (REG_ADDR == OFS_STATUS);
  wire logic        wr_sh_hi  = reg_sel && REG_WR && (REG_ADDR == OFS_SHIFT_HI);
  wire logic        wr_sh_lo  = reg_sel && REG_WR && (REG_ADDR == OFS_SHIFT_LO);
  wire logic        wr_ccr    = reg_sel && REG_WR && (REG_ADDR == OFS_CCR);
  wire logic        background_pin_fall = background_pin_d_ff && !background_pin_s;

  // entry needs enable and no lockout
  wire logic        enter_ok  = (ENTER_REQ || (CMD_STROBE && CMD_BYTE == OPC_BACKGROUND))
                                && enable_ff && lockout_off_ff && !active_ff;
  wire logic        tag_start = TAG_GO_CMD || st_wr;
  wire logic [7:0]  status_rd = {enable_ff, active_ff, tag_ff, sdv_ff, trace_ff, clksel_ff, 2'b00};

  // read mux as a named chain; reads outside FF00-FF06 are not captured and REG_RDATA keeps its value
  wire logic [7:0]  nxt_rdata = (REG_ADDR == OFS_INSTR)    ? instr_ff :
                                (REG_ADDR == OFS_STATUS)   ? status_rd :
                                (REG_ADDR == OFS_SHIFT_HI) ? shift_ff[15:8] :
                                (REG_ADDR == OFS_SHIFT_LO) ? shift_ff[7:0] :
                                (REG_ADDR == OFS_ADDR_HI)  ? addr_ff[15:8] :
                                (REG_ADDR == OFS_ADDR_LO)  ? addr_ff[7:0] :
                                (REG_ADDR == OFS_CCR)      ? ccr_ff : 8'h00;

  // hardware command clears its two low bits; firmware keeps register field
  wire logic [7:0]  cmd_instr = CMD_BYTE[IN_HW] ? (CMD_BYTE & HW_LOW_MASK) : CMD_BYTE;
  wire logic [7:0]  nxt_instr = CMD_STROBE ? cmd_instr :
                                wr_instr   ? REG_WDATA :
                                tmo_done   ? INSTR_RST : instr_ff;

  // write delays on the active and tagging flags, and the background pin timeout
  bdc_delay #(.COUNT(ACT_DLY_CYC)) u_act_dly (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .start (st_wr && !instr_ff[IN_HW]),
    .busy  (),
    .done  (act_done)
  );
  bdc_delay #(.COUNT(TAG_DLY_CYC)) u_tag_dly (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .start (tag_start),
    .busy  (tag_busy),
    .done  (tag_done)
  );
  bdc_delay #(.COUNT(TMO_CYC)) u_tmo (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .start (background_pin_fall),
    .busy  (),
    .done  (tmo_done)
  );

  // status next values; hardware sets win over software writes
  wire logic nxt_enable = st_wr ? REG_WDATA[ST_ENABLE] : enable_ff;
  wire logic nxt_active = enter_ok ? 1'b1 :
                          act_done ? (act_wval_ff && lockout_off_ff) : active_ff;
  wire logic nxt_tag    = enter_ok ? 1'b0 : TAG_GO_CMD ? 1'b1 :
                          st_wr ? REG_WDATA[ST_TAG] : tag_ff;
  wire logic nxt_sdv    = SHIFT_DONE ? 1'b1 : SHIFT_START ? 1'b0 :
                          st_wr ? REG_WDATA[ST_SDV] : sdv_ff;
  wire logic nxt_trace  = SINGLE_STEP_CMD ? 1'b1 : st_wr ? REG_WDATA[ST_TRACE] : trace_ff;
  wire logic nxt_clksel = (st_wr && instr_ff[IN_HW]) ? REG_WDATA[ST_CLKSEL] : clksel_ff;
  wire logic nxt_live   = enter_ok ? 1'b0 : tag_done ? tag_ff : tag_live_ff;
  wire logic nxt_lock   = (LOCK_WR && !special_n_s) ? LOCK_WDATA : lockout_off_ff;

  // memory stealing: hold buses until done, new request wins
  wire logic nxt_pend   = MEM_REQ ? 1'b1 : MEM_DONE ? 1'b0 : mem_pend_ff;
  wire logic nxt_multi  = MEM_REQ ? MEM_MULTI : mem_multi_ff;

  // instruction, data holding and read registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      instr_ff  <= INSTR_RST;
      shift_ff  <= 16'h0000;
      addr_ff   <= 16'h0000;
      ccr_ff    <= 8'h00;
      rdata_ff  <= 8'h00;
      background_pin_d_ff <= 1'b1;
    end else begin
      instr_ff  <= nxt_instr;
      shift_ff  <= SHIFT_DATA_IN & {16{SHIFT_DONE}}
                   | {wr_sh_hi ? REG_WDATA : shift_ff[15:8], wr_sh_lo ? REG_WDATA : shift_ff[7:0]}
                   & {16{!SHIFT_DONE}};
      addr_ff   <= ADDR_LOAD ? ADDR_IN : addr_ff;
      ccr_ff    <= CCR_LOAD ? CCR_IN : (wr_ccr ? REG_WDATA : ccr_ff);
      rdata_ff  <= (reg_sel && REG_RD) ? nxt_rdata : rdata_ff;
      background_pin_d_ff <= background_pin_s;
    end
  end

  // status flags; active flag strap is caught in the synchronous reset
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      enable_ff   <= 1'b0;
      active_ff   <= (MODE_SPECIAL_SC || MODE_PERIPH) && SHADOW_LOCKOUT_OFF;
      tag_ff      <= 1'b0;
      tag_live_ff <= 1'b0;
      sdv_ff      <= 1'b0;
      trace_ff    <= 1'b0;
      clksel_ff   <= 1'b0;
      act_wval_ff <= 1'b0;
    end else begin
      enable_ff   <= nxt_enable;
      active_ff   <= nxt_active;
      tag_ff      <= nxt_tag;
      tag_live_ff <= nxt_live;
      sdv_ff      <= nxt_sdv;
      trace_ff    <= nxt_trace;
      clksel_ff   <= nxt_clksel;
      act_wval_ff <= (st_wr && !instr_ff[IN_HW]) ? REG_WDATA[ST_ACTIVE] : act_wval_ff;
    end
  end

  // lockout bit reloads from the shadow byte on every reset
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      lockout_off_ff <= SHADOW_LOCKOUT_OFF;
      mem_pend_ff    <= 1'b0;
      mem_multi_ff   <= 1'b0;
    end else begin
      lockout_off_ff <= nxt_lock;
      mem_pend_ff    <= nxt_pend;
      mem_multi_ff   <= nxt_multi;
    end
  end

  // outputs; freeze only when the access cannot finish in one cycle
  assign REG_HIT          = reg_sel;
  assign REG_RDATA        = rdata_ff;
  assign BUS_HOLD         = mem_pend_ff;
  assign CPU_FREEZE       = mem_pend_ff && mem_multi_ff;
  assign DEBUG_ACTIVE     = active_ff;
  assign DEBUG_MAP_EN     = map_en;
  assign FW_CMD_ALLOWED   = enable_ff && lockout_off_ff && !tag_live_ff;
  assign LOCKOUT_OFF      = lockout_off_ff;
  assign RESET_VEC_RUN_EN = lockout_off_ff || !special_sc_s;
  assign TAG_ENABLE       = tag_live_ff;
  assign SERIAL_DISABLE   = tag_busy || tag_live_ff;
  assign DEBUG_CLK_SEL    = clksel_ff || sys_slow_s;
  assign XFER_WORD        = instr_ff[IN_WORD];
  assign SHIFT_DATA       = shift_ff;
  assign ADDR_HOLD        = addr_ff;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // lockout, bus hold, write delay, status flag, clock and timeout checks
  a_lock_entry:   assert property (!lockout_off_ff |=> !active_ff && !DEBUG_MAP_EN)
    else $error("active or mapped under lockout");
  a_lock_mode:    assert property (special_n_s |=> $stable(lockout_off_ff))
    else $error("lockout bit changed outside special mode");
  a_bus_freeze:   assert property (CPU_FREEZE |-> BUS_HOLD)
    else $error("freeze without bus hold");
  a_bus_keep:     assert property (BUS_HOLD && !MEM_DONE |=> BUS_HOLD)
    else $error("bus released before done");
  a_act_delay:    assert property ((st_wr && !instr_ff[IN_HW]) ##1 (!st_wr && !enter_ok)[*4]
                                   |=> active_ff == (act_wval_ff && lockout_off_ff))
    else $error("active flag write not applied after 4 cycles");
  a_act_early:    assert property ((st_wr && !instr_ff[IN_HW] && !enter_ok) ##1 !enter_ok
                                   |-> $stable(active_ff))
    else $error("active flag changed too early");
  a_tag_serial:   assert property (tag_start |=> SERIAL_DISABLE[*8])
    else $error("serial not disabled during tag delay");
  a_tag_entry:    assert property (enter_ok |=> !tag_ff && !TAG_ENABLE)
    else $error("tagging not cleared on entry");
  a_sdv_set:      assert property (SHIFT_DONE |=> sdv_ff)
    else $error("shifter valid not set");
  a_trace_set:    assert property (SINGLE_STEP_CMD |=> trace_ff)
    else $error("trace not set on single step");
  a_clksel_guard: assert property (st_wr && !instr_ff[IN_HW] |=> $stable(clksel_ff))
    else $error("clock select written by firmware");
  a_clk_slow:     assert property (sys_slow_s |-> DEBUG_CLK_SEL)
    else $error("slow system clock not forced");
  a_tmo_clear:    assert property (tmo_done && !CMD_STROBE && !wr_instr |=> instr_ff == INSTR_RST)
    else $error("instruction not cleared on timeout");
  a_rsvd_zero:    assert property (reg_sel && REG_RD && REG_ADDR == OFS_STATUS |=> REG_RDATA[1:0] == 2'b00)
    else $error("reserved status bits nonzero");

  // mapping and instruction fields
  a_hit_range:    assert property (REG_HIT |-> REG_ADDR >= OFS_INSTR && REG_ADDR <= OFS_CCR)
    else $error("register hit outside debug space");
  a_map_off:      assert property (!active_ff && !(instr_ff[IN_HW] && instr_ff[IN_MAP]) |-> !DEBUG_MAP_EN)
    else $error("debug space mapped without map flag");
  a_hw_low:       assert property (CMD_STROBE && CMD_BYTE[IN_HW] |=> instr_ff[1:0] == 2'b00)
    else $error("hardware command low bits kept");

  // status flag updates
  a_sdv_clear:    assert property (SHIFT_START && !SHIFT_DONE |=> !sdv_ff)
    else $error("shifter valid not cleared");
  a_trace_keep:   assert property (!SINGLE_STEP_CMD && !st_wr |=> $stable(trace_ff))
    else $error("trace changed without cause");
  a_tag_live:     assert property (tag_done && !enter_ok |=> TAG_ENABLE == $past(tag_ff))
    else $error("tagging not applied after delay");
  a_clk_write:    assert property (st_wr && instr_ff[IN_HW] && REG_WDATA[ST_CLKSEL] |=> clksel_ff)
    else $error("clock select write lost");
  a_en_clear:     assert property (st_wr && !REG_WDATA[ST_ENABLE] |=> !FW_CMD_ALLOWED)
    else $error("firmware allowed after enable cleared");
  a_no_entry:     assert property (!enable_ff && !active_ff |=> !active_ff)
    else $error("active mode entered while disabled");

  // lockout and reset vector
  a_lock_take:    assert property (LOCK_WR && !special_n_s |=> lockout_off_ff == $past(LOCK_WDATA))
    else $error("lockout write lost in special mode");
  a_rv_block:     assert property (!lockout_off_ff && special_sc_s |-> !RESET_VEC_RUN_EN)
    else $error("reset vector run allowed under lockout");

  // bus stealing
  a_bus_take:     assert property (MEM_REQ |=> BUS_HOLD)
    else $error("bus not held after request");
  a_bus_free:     assert property (MEM_DONE && !MEM_REQ |=> !BUS_HOLD)
    else $error("bus held after done");
  a_freeze_multi: assert property (MEM_REQ && MEM_MULTI |=> CPU_FREEZE)
    else $error("multi-cycle access did not freeze");

  // main scenarios reached
  c_entry:  cover property (enter_ok ##1 DEBUG_ACTIVE);
  c_tag:    cover property ($rose(TAG_ENABLE));
  c_tmo:    cover property (tmo_done);
  c_freeze: cover property (CPU_FREEZE ##1 !BUS_HOLD);
  c_steal:  cover property (BUS_HOLD && !CPU_FREEZE);
endmodule : bdc_ctrl

// ---- tb/bdc_host.sv ----
`timescale 1ns/10ps
module bdc_host
  import bdc_pkg::*;
(
  // debug clock
  input  wire logic clk,
  // pin level and serial engine events
  output logic       background_pin,
  output logic       cmd_stb,
  output logic [7:0] cmd_byte,
  output logic       s_start,
  output logic       s_done,
  output logic       step,
  output logic       tag_go,
  output logic       enter
);
  int         cyc      = 0;
  int         ready_at = 0;
  logic [4:0] ev_q     = 5'h00;
  // all event strobes but cmd_stb share one vector so a single task drives them
  assign {s_start, s_done, step, tag_go, enter} = ev_q;
  initial begin
    background_pin = 1'b1;
    cmd_stb = 1'b0;
    cmd_byte = 8'h00;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // one-cycle strobe set and dropped on falling edges
  task automatic fire(input logic [4:0] m);
    @(negedge clk);
    ev_q = m;
    @(negedge clk);
    ev_q = 5'h00;
    if (m[2] || m[1]) ready_at = cyc + HOST_EXIT_CYC;
  endtask : fire
  // a new command never starts inside the quiet time of the last one
  task automatic cmd(input logic [7:0] b);
    for (int n = 0; n < 200 && cyc < ready_at; n++) @(negedge clk);
    if (cyc < ready_at) tb.fail_wait();
    @(negedge clk);
    cmd_byte = b;
    cmd_stb = 1'b1;
    @(negedge clk);
    cmd_stb = 1'b0;
    cmd_byte = ~b; // stale value would hide a late sample
    if (!b[7] && b[6] && !b[5]) ready_at = cyc + HOST_FWWR_CYC;
  endtask : cmd
  // one falling edge on the pulled-up pin
  task automatic fall();
    @(negedge clk);
    background_pin = 1'b0;
    @(negedge clk);
    background_pin = 1'b1;
  endtask : fall
endmodule : bdc_host

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  import bdc_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, spec_n = 1'b0, mode_sc = 1'b0, slow = 1'b0, shadow = 1'b1;
  logic lock_wr = 1'b0, lock_wd = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, addr_ld = 1'b0;
  logic mem_req = 1'b0, mem_multi = 1'b0, mem_done = 1'b0, periph = 1'b0, ccr_ld = 1'b0;
  logic [15:0] reg_addr = 16'h0000, sdin = 16'h0000, addr_in = 16'h0000;
  logic [7:0] reg_wd = 8'h00, ccr_in = 8'h00, reg_rdata, cmd_byte;
  logic reg_hit, background_pin, cmd_stb, s_start, s_done, step, tag_go, enter, bus_hold, cpu_freeze;
  logic active, map_en, fw_ok, lock_off, rv_en, tag_en, ser_dis, clk_sel, xfer_word;
  logic [15:0] shift_data, addr_hold;
  int err_count = 0, check_count = 0;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  bdc_host host (.clk(clk_sys), .background_pin(background_pin), .cmd_stb(cmd_stb), .cmd_byte(cmd_byte), .s_start(s_start),
    .s_done(s_done), .step(step), .tag_go(tag_go), .enter(enter));
  // every strap and load input is driven by the scenarios
  bdc_ctrl uut (.CLK_SYS(clk_sys), .RESET(reset), .BACKGROUND_PIN_IN(background_pin), .SPECIAL_MODE_N(spec_n),
    .MODE_SPECIAL_SC(mode_sc), .MODE_PERIPH(periph), .SYS_CLK_SLOW(slow), .SHADOW_LOCKOUT_OFF(shadow),
    .LOCK_WR(lock_wr), .LOCK_WDATA(lock_wd), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wd), .REG_HIT(reg_hit), .REG_RDATA(reg_rdata), .CMD_STROBE(cmd_stb), .CMD_BYTE(cmd_byte),
    .SHIFT_START(s_start), .SHIFT_DONE(s_done), .SHIFT_DATA_IN(sdin), .ADDR_LOAD(addr_ld), .ADDR_IN(addr_in),
    .ENTER_REQ(enter), .SINGLE_STEP_CMD(step), .TAG_GO_CMD(tag_go), .CCR_LOAD(ccr_ld), .CCR_IN(ccr_in),
    .MEM_REQ(mem_req), .MEM_MULTI(mem_multi), .MEM_DONE(mem_done), .BUS_HOLD(bus_hold),
    .CPU_FREEZE(cpu_freeze), .DEBUG_ACTIVE(active), .DEBUG_MAP_EN(map_en), .FW_CMD_ALLOWED(fw_ok),
    .LOCKOUT_OFF(lock_off), .RESET_VEC_RUN_EN(rv_en), .TAG_ENABLE(tag_en), .SERIAL_DISABLE(ser_dis),
    .DEBUG_CLK_SEL(clk_sel), .XFER_WORD(xfer_word), .SHIFT_DATA(shift_data), .ADDR_HOLD(addr_hold));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // reset held three edges so the synchronisers flush
  task automatic do_reset(input logic sh, input logic sc);
    shadow = sh;
    mode_sc = sc;
    reset = 1'b1;
    tick(3);
    reset = 1'b0;
    tick(2);
  endtask : do_reset
  // bus strobes rise one edge after any earlier drop
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tick(1);
    reg_addr = a;
    reg_wd = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    tick(1);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk($sformatf("rdata %h", a), e, reg_rdata);
  endtask : rd
  task automatic lockw(input logic d);
    tick(3);
    lock_wd = d;
    lock_wr = 1'b1;
    tick(1);
    lock_wr = 1'b0;
  endtask : lockw
  task automatic t_special();
    do_reset(1'b1, 1'b1);
    chk("active", 1, active);
    chk("lockout off", 1, lock_off);
    chk("reset vector", 1, rv_en);
    rd(OFS_STATUS, 8'h40);
    rd(OFS_INSTR, INSTR_RST);
    periph = 1'b1;
    do_reset(1'b1, 1'b0);
    chk("active", 1, active);
    periph = 1'b0;
    $display("done: special reset");
  endtask : t_special
  task automatic t_lockout();
    do_reset(1'b0, 1'b1);
    chk("active", 0, active);
    chk("lockout off", 0, lock_off);
    chk("reset vector", 0, rv_en);
    host.cmd(8'hC4);
    reg_addr = OFS_STATUS;
    #1 chk("hit", 0, reg_hit);
    host.fire(5'b00001);
    chk("active", 0, active);
    spec_n = 1'b1;
    lockw(1'b1);
    chk("lockout off", 0, lock_off);
    spec_n = 1'b0;
    lockw(1'b1);
    chk("lockout off", 1, lock_off);
    do_reset(1'b1, 1'b0);
    chk("lockout off", 1, lock_off);
    chk("active", 0, active);
    $display("done: lockout");
  endtask : t_lockout
  task automatic t_regs();
    host.cmd(8'hC0);
    reg_addr = OFS_STATUS;
    #1 chk("hit", 0, reg_hit);
    host.cmd(8'hC4);
    chk("word", 0, xfer_word);
    for (int a = 16'hFF00; a <= 16'hFF07; a++) begin
      tick(1);
      reg_addr = a[15:0];
      #1 chk("hit", {15'h0, a != 16'hFF07}, reg_hit);
    end
    wr(OFS_STATUS, 8'hFF);
    tick(5);
    rd(OFS_STATUS, 8'hBC);
    chk("clock select", 1, clk_sel);
    tick(HOST_CLOCK_SELECT_BIT_CYC);
    wr(OFS_STATUS, 8'h80);
    rd(OFS_STATUS, 8'h80);
    wr(OFS_ADDR_HI, 8'hAA);
    rd(OFS_ADDR_HI, 8'h00);
    $display("done: register map");
  endtask : t_regs
  task automatic t_active();
    host.fire(5'b00001);
    chk("active", 1, active);
    host.cmd(8'h00);
    wr(OFS_STATUS, 8'h80);
    for (int i = 0; i < 3; i++) begin
      tick(1);
      chk("active held", 1, active);
    end
    tick(1);
    chk("active", 0, active);
    host.cmd(8'hC4);
    wr(OFS_STATUS, 8'h00);
    chk("fw allowed", 0, fw_ok);
    host.fire(5'b00001);
    chk("active", 0, active);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_STATUS, 8'h80);
    host.cmd(OPC_BACKGROUND);
    chk("active", 1, active);
    chk("fw allowed", 1, fw_ok);
    $display("done: active mode");
  endtask : t_active
  task automatic t_tag();
    host.fire(5'b00010);
    chk("serial off", 1, ser_dis);
    chk("fw allowed", 1, fw_ok);
    tick(15);
    chk("tag enable", 0, tag_en);
    tick(1);
    chk("tag enable", 1, tag_en);
    chk("fw allowed", 0, fw_ok);
    $display("done: tagging");
  endtask : t_tag
  task automatic t_shift();
    host.fire(5'b10000);
    rd(OFS_STATUS, 8'hE0);
    sdin = 16'hA55A;
    host.fire(5'b01000);
    chk("shift data", 16'hA55A, shift_data);
    rd(OFS_STATUS, 8'hF0);
    rd(OFS_SHIFT_HI, 8'hA5);
    rd(OFS_SHIFT_LO, 8'h5A);
    host.fire(5'b00100);
    rd(OFS_STATUS, 8'hF8);
    addr_in = 16'h1234;
    addr_ld = 1'b1;
    tick(1);
    addr_ld = 1'b0;
    rd(OFS_ADDR_HI, 8'h12);
    rd(OFS_ADDR_LO, 8'h34);
    wr(OFS_CCR, 8'h3C);
    rd(OFS_CCR, 8'h3C);
    ccr_in = 8'hC3;
    ccr_ld = 1'b1;
    tick(1);
    ccr_ld = 1'b0;
    rd(OFS_CCR, 8'hC3);
    $display("done: shifter");
  endtask : t_shift
  // single-cycle access leaves the processor running, multi-cycle freezes it
  task automatic t_steal();
    for (int m = 0; m < 2; m++) begin
      tick(1);
      mem_multi = m[0];
      mem_req = 1'b1;
      tick(1);
      mem_req = 1'b0;
      tick(3);
      chk("bus hold", 1, bus_hold);
      chk("freeze", {15'h0, m[0]}, cpu_freeze);
      mem_done = 1'b1;
      tick(1);
      mem_done = 1'b0;
      tick(1);
      chk("bus hold", 0, bus_hold);
      chk("freeze", 0, cpu_freeze);
    end
    $display("done: cycle steal");
  endtask : t_steal
  task automatic t_clk_tmo();
    slow = 1'b1;
    tick(3);
    chk("clock select", 1, clk_sel);
    slow = 1'b0;
    tick(3);
    chk("clock select", 0, clk_sel);
    host.cmd(8'hCC);
    chk("word", 1, xfer_word);
    host.fall();
    tick(480);
    chk("word", 1, xfer_word);
    tick(60);
    chk("word", 0, xfer_word);
    $display("done: clock and timeout");
  endtask : t_clk_tmo
  task automatic fail_wait();
    err_count++;
    test_done();
  endtask : fail_wait
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    t_special();
    t_lockout();
    t_regs();
    t_active();
    t_tag();
    t_shift();
    t_steal();
    t_clk_tmo();
    test_done();
  end
endmodule : tb
